/* File: verilog/haptic_drive_loop_config.sv */
// Drive loop configuration register and loop/brake/standby sequencing
// Behaviour
// RQ1: Bit 7 selects actuator type, resets resonant.
// RQ2: Host sets actuator type before calibration.
// RQ3: Bit 6 selects closed or open loop.
// RQ4: Bit 5 selects full or hybrid closed loop.
// RQ5: Open-loop autobrake: nonpositive sample brakes closed-loop.
// RQ6: Positive samples still play open loop.
// RQ7: Open-loop autobrake off after reset.
// RQ8: Host enables autobrake only after calibration.
// RQ9: Standby request while playing brakes first.
// RQ10: Brake only if actuator is moving.
// RQ11: Bit clear: standby at once; resets set.
// RQ12: Step check: open loop unless step large.
// RQ13: Step check ignored outside hybrid mode.
// RQ14: Level trigger deassertion requests standby.
// RQ15: Mode rewrite during process forces standby.
// RQ16: Step threshold fixed, absolute amplitude difference.
// RQ17: Reserved bits store, read back, no effect.
`timescale 1ns/10ps
module haptic_drive_loop_config (
    input  wire logic                                 sys_clk,
    input  wire logic                                 nrst,
    input  wire logic                                 reg_wr,
    input  wire logic                                 reg_rd,
    input  wire logic [7:0]                           reg_addr,
    input  wire logic [7:0]                           reg_wdata,
    output logic [7:0]                                reg_rdata,
    output logic                                      reg_rvalid,
    input  wire logic                                 play_start,
    input  wire logic                                 play_done,
    input  wire logic                                 idle_timeout,
    input  wire logic                                 trig_level_mode,
    input  wire logic                                 trigger_irq_pin_in,
    input  wire logic                                 mode_rewrite,
    input  wire logic                                 actuator_moving,
    input  wire logic                                 brake_done,
    input  wire logic                                 sample_valid,
    input  wire logic [haptic_loop_pkg::SAMPLE_W-1:0] sample_data,
    output logic                                      actuator_type_sel,
    output haptic_loop_pkg::drive_out_type            drive
);

    // ************************************************************
    // State
    // ************************************************************
    haptic_loop_pkg::main_state_type cur;
    haptic_loop_pkg::main_state_type next_cur;
    logic                            large_step;
    logic                            lvl_drop;
    logic                            stby_req;
    logic                            cfg_hit;
    logic [1:0]                      dec;

    step_check u_step (
        .sys_clk      (sys_clk),
        .nrst         (nrst),
        .sample_valid (sample_valid),
        .sample_data  (sample_data),
        .large_step   (large_step)
    );

    // Returns {closed loop, brake} for one sample
    function automatic logic [1:0] loop_decision(
        input haptic_loop_pkg::loop_cfg_type        c,
        input logic [haptic_loop_pkg::SAMPLE_W-1:0] s,
        input logic                                 big
    );
        logic nonpos;
        nonpos = s[haptic_loop_pkg::SAMPLE_W-1] || (s == haptic_loop_pkg::SAMPLE_ZERO);
        if (c.open_loop_sel == haptic_loop_pkg::LOOP_OPEN) begin // RQ3
            if (c.open_loop_autobrake_en && nonpos) begin // RQ5 RQ7
                loop_decision = 2'b11;
            end else begin
                loop_decision = 2'b00; // RQ6
            end
        end else if (c.hybrid_loop_sel && c.input_step_check_en) begin // RQ4 RQ13
            loop_decision = {big, 1'b0}; // RQ12
        end else begin
            loop_decision = 2'b10;
        end
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_cur = cur;
        next_cur.rvalid = 1'b0;
        cfg_hit = (reg_addr == haptic_loop_pkg::CFG_OFFSET);
        // All eight bits stored, reserved ones included
        if (reg_wr && cfg_hit) begin
            next_cur.cfg = haptic_loop_pkg::loop_cfg_type'(reg_wdata); // RQ17
        end
        if (reg_rd) begin
            next_cur.rvalid = 1'b1;
            next_cur.rdata = cfg_hit ? cur.cfg : haptic_loop_pkg::RD_UNMAPPED;
        end
        next_cur.trig_prev = trigger_irq_pin_in;
        lvl_drop = trig_level_mode && cur.trig_prev && !trigger_irq_pin_in; // RQ14
        stby_req = idle_timeout || lvl_drop;
        case (cur.st)
            haptic_loop_pkg::ST_STANDBY: begin
                if (play_start) begin
                    next_cur.st = haptic_loop_pkg::ST_PLAY;
                end
            end
            haptic_loop_pkg::ST_PLAY: begin
                if (stby_req) begin
                    next_cur.st = cur.cfg.standby_autobrake_en ? haptic_loop_pkg::ST_CHECK
                                                               : haptic_loop_pkg::ST_STANDBY; // RQ9 RQ11
                end else if (play_done) begin
                    next_cur.st = haptic_loop_pkg::ST_STANDBY;
                end
            end
            haptic_loop_pkg::ST_CHECK: begin
                // One cycle to look at the motion sense before committing to a brake
                next_cur.st = actuator_moving ? haptic_loop_pkg::ST_BRAKE
                                              : haptic_loop_pkg::ST_STANDBY; // RQ10
            end
            haptic_loop_pkg::ST_BRAKE: begin
                if (brake_done) begin
                    next_cur.st = haptic_loop_pkg::ST_STANDBY;
                end
            end
            default: begin
                next_cur.st = haptic_loop_pkg::ST_STANDBY;
            end
        endcase
        // Overrides any braking in progress; the mode change wins
        if (mode_rewrite) begin
            next_cur.st = haptic_loop_pkg::ST_STANDBY; // RQ15
        end
        dec = loop_decision(cur.cfg, sample_data, large_step);
        if (cur.st == haptic_loop_pkg::ST_PLAY && sample_valid) begin
            next_cur.drive.closed_loop = dec[1];
            next_cur.sample_brake = dec[0];
        end
        if (next_cur.st != haptic_loop_pkg::ST_PLAY) begin
            next_cur.sample_brake = 1'b0;
        end
        if (next_cur.st == haptic_loop_pkg::ST_BRAKE) begin
            next_cur.drive.closed_loop = 1'b1;
        end
        next_cur.drive.hybrid = (next_cur.cfg.open_loop_sel == haptic_loop_pkg::LOOP_CLOSED)
                                && next_cur.cfg.hybrid_loop_sel; // RQ4
        next_cur.drive.brake = (next_cur.st == haptic_loop_pkg::ST_BRAKE) || next_cur.sample_brake;
        next_cur.drive.standby = (next_cur.st == haptic_loop_pkg::ST_STANDBY);
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cur <= '0;
            cur.cfg <= haptic_loop_pkg::CFG_RESET; // RQ1 RQ7 RQ11
            cur.st <= haptic_loop_pkg::ST_STANDBY;
            cur.drive.closed_loop <= 1'b1;
            cur.drive.standby <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign reg_rdata = cur.rdata;
    assign reg_rvalid = cur.rvalid;
    assign actuator_type_sel = cur.cfg.actuator_type_sel; // RQ1
    assign drive = cur.drive;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    logic play_smp;
    logic steady;
    assign play_smp = (cur.st == haptic_loop_pkg::ST_PLAY) && sample_valid;
    assign steady = !stby_req && !play_done && !mode_rewrite;

    property p_act_type;
        reg_wr && cfg_hit |=> actuator_type_sel == $past(reg_wdata[7]);
    endproperty
    a_act_type: assert property (p_act_type) else $error("actuator type not stored"); // RQ1

    property p_open_loop;
        play_smp && cur.cfg.open_loop_sel && !cur.cfg.open_loop_autobrake_en
            |=> !drive.closed_loop && !drive.brake;
    endproperty
    a_open_loop: assert property (p_open_loop) else $error("open loop not honoured"); // RQ3 RQ7

    property p_ol_brake;
        play_smp && steady && cur.cfg.open_loop_sel && cur.cfg.open_loop_autobrake_en
            && (sample_data[haptic_loop_pkg::SAMPLE_W-1] || sample_data == '0)
            |=> drive.closed_loop && drive.brake;
    endproperty
    a_ol_brake: assert property (p_ol_brake) else $error("no brake on nonpositive"); // RQ5

    property p_ol_positive;
        play_smp && cur.cfg.open_loop_sel && !sample_data[haptic_loop_pkg::SAMPLE_W-1]
            && sample_data != '0 |=> !drive.closed_loop && !drive.brake;
    endproperty
    a_ol_positive: assert property (p_ol_positive) else $error("positive not open"); // RQ6

    property p_stby_brake;
        cur.st == haptic_loop_pkg::ST_PLAY && stby_req && !mode_rewrite
            && cur.cfg.standby_autobrake_en
            |=> cur.st == haptic_loop_pkg::ST_CHECK ##1 (drive.brake != drive.standby);
    endproperty
    a_stby_brake: assert property (p_stby_brake) else $error("standby brake skipped"); // RQ9 RQ10

    property p_stby_direct;
        cur.st == haptic_loop_pkg::ST_PLAY && stby_req && !cur.cfg.standby_autobrake_en
            |=> drive.standby && !drive.brake;
    endproperty
    a_stby_direct: assert property (p_stby_direct) else $error("standby delayed"); // RQ11

    property p_step;
        play_smp && !cur.cfg.open_loop_sel && cur.cfg.hybrid_loop_sel
            && cur.cfg.input_step_check_en |=> drive.closed_loop == $past(large_step);
    endproperty
    a_step: assert property (p_step) else $error("step check wrong"); // RQ12 RQ16

    property p_no_hybrid;
        play_smp && !cur.cfg.open_loop_sel && !cur.cfg.hybrid_loop_sel |=> drive.closed_loop;
    endproperty
    a_no_hybrid: assert property (p_no_hybrid) else $error("step check not ignored"); // RQ13

    property p_level_drop;
        cur.st == haptic_loop_pkg::ST_PLAY && trig_level_mode && cur.trig_prev
            && !trigger_irq_pin_in |=> cur.st != haptic_loop_pkg::ST_PLAY;
    endproperty
    a_level_drop: assert property (p_level_drop) else $error("level drop ignored"); // RQ14

    property p_mode_rw;
        mode_rewrite |=> drive.standby && !drive.brake;
    endproperty
    a_mode_rw: assert property (p_mode_rw) else $error("mode rewrite no standby"); // RQ15

    property p_readback;
        reg_wr && cfg_hit ##1 reg_rd && cfg_hit && !reg_wr |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch"); // RQ17

    property p_hybrid_flag;
        reg_wr && cfg_hit |=> drive.hybrid == (!$past(reg_wdata[6]) && $past(reg_wdata[5]));
    endproperty
    a_hybrid_flag: assert property (p_hybrid_flag) else $error("hybrid flag wrong"); // RQ4

    // Motion check decides between a brake phase and a direct park
    property p_check_move;
        cur.st == haptic_loop_pkg::ST_CHECK && actuator_moving && !mode_rewrite
            |=> drive.brake && drive.closed_loop && !drive.standby;
    endproperty
    a_check_move: assert property (p_check_move) else $error("moving actuator not braked"); // RQ10

    property p_check_still;
        cur.st == haptic_loop_pkg::ST_CHECK && !actuator_moving
            |=> drive.standby && !drive.brake;
    endproperty
    a_check_still: assert property (p_check_still) else $error("still actuator braked"); // RQ10

    property p_brake_hold;
        cur.st == haptic_loop_pkg::ST_BRAKE && !brake_done && !mode_rewrite
            |=> drive.brake && drive.closed_loop && !drive.standby;
    endproperty
    a_brake_hold: assert property (p_brake_hold) else $error("brake dropped early"); // RQ9

    property p_brake_end;
        cur.st == haptic_loop_pkg::ST_BRAKE && brake_done |=> drive.standby && !drive.brake;
    endproperty
    a_brake_end: assert property (p_brake_end) else $error("no standby after brake"); // RQ9

    property p_stby_idle;
        cur.st == haptic_loop_pkg::ST_STANDBY && idle_timeout && !play_start
            |=> drive.standby && !drive.brake;
    endproperty
    a_stby_idle: assert property (p_stby_idle) else $error("brake without playback"); // RQ9

    property p_step_ignored;
        play_smp && !cur.cfg.open_loop_sel && !cur.cfg.hybrid_loop_sel
            && cur.cfg.input_step_check_en && !large_step |=> drive.closed_loop;
    endproperty
    a_step_ignored: assert property (p_step_ignored) else $error("step check applied"); // RQ13

    property p_rd_answer;
        reg_rd |=> reg_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

    property p_rvalid_pulse;
        !reg_rd |=> !reg_rvalid;
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without read");

    property p_unmapped_rd;
        reg_rd && !cfg_hit |=> reg_rdata == haptic_loop_pkg::RD_UNMAPPED;
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

    c_ol_brake: cover property (play_smp && cur.cfg.open_loop_sel ##1 drive.brake);
    c_stby_brk: cover property (cur.st == haptic_loop_pkg::ST_CHECK ##1
                                cur.st == haptic_loop_pkg::ST_BRAKE);
    c_hyb_big: cover property (play_smp && cur.cfg.hybrid_loop_sel && large_step);
    c_mode_rw: cover property (cur.st == haptic_loop_pkg::ST_BRAKE && mode_rewrite);
    c_lvl_drop: cover property (cur.st == haptic_loop_pkg::ST_PLAY && lvl_drop);

endmodule // haptic_drive_loop_config

/* File: verilog/haptic_loop_pkg.sv */
// Constants and types shared by the drive loop configuration block
package haptic_loop_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] CFG_OFFSET = 8'h08;
    localparam logic [7:0] CFG_RESET  = 8'h88;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ************************************************************
    // Field encodings
    // ************************************************************
    localparam logic ACT_ROTATING_MASS = 1'b0;
    localparam logic ACT_RESONANT_LIN  = 1'b1;
    localparam logic LOOP_CLOSED       = 1'b0;
    localparam logic LOOP_OPEN         = 1'b1;

    // ************************************************************
    // Sample path
    // ************************************************************
    localparam int         SAMPLE_W       = 8;
    localparam logic [7:0] STEP_THRESHOLD = 8'h20;
    localparam logic [7:0] SAMPLE_ZERO    = 8'h00;

    typedef struct packed {
        logic       actuator_type_sel;
        logic       open_loop_sel;
        logic       hybrid_loop_sel;
        logic       open_loop_autobrake_en;
        logic       standby_autobrake_en;
        logic       input_step_check_en;
        logic [1:0] reserved;
    } loop_cfg_type;

    typedef enum logic [1:0] {
        ST_STANDBY = 2'b00,
        ST_PLAY    = 2'b01,
        ST_CHECK   = 2'b10,
        ST_BRAKE   = 2'b11
    } drive_state_type;

    typedef struct packed {
        logic closed_loop;
        logic hybrid;
        logic brake;
        logic standby;
    } drive_out_type;

    typedef struct packed {
        loop_cfg_type    cfg;
        drive_state_type st;
        logic [7:0]      rdata;
        logic            rvalid;
        logic            trig_prev;
        logic            sample_brake;
        drive_out_type   drive;
    } main_state_type;

    typedef struct packed {
        logic [SAMPLE_W-1:0] prev;
    } step_state_type;

endpackage

/* File: verilog/step_check.sv */
// Step-size detector between consecutive requested amplitudes
`timescale 1ns/10ps
module step_check #(
    parameter logic [7:0] THRESHOLD = haptic_loop_pkg::STEP_THRESHOLD
) (
    input  wire logic                                 sys_clk,
    input  wire logic                                 nrst,
    input  wire logic                                 sample_valid,
    input  wire logic [haptic_loop_pkg::SAMPLE_W-1:0] sample_data,
    output logic                                      large_step
);
    localparam int W = haptic_loop_pkg::SAMPLE_W;

    haptic_loop_pkg::step_state_type cur;
    haptic_loop_pkg::step_state_type next_cur;
    logic signed [W:0]               diff;
    logic        [W:0]               mag;

    // Sign-extend by one bit so the difference never overflows
    always_comb begin
        diff = $signed({cur.prev[W-1], cur.prev}) - $signed({sample_data[W-1], sample_data});
        mag = diff[W] ? (W+1)'(-diff) : diff;
        large_step = (mag >= {1'b0, THRESHOLD}); // RQ16
        next_cur = cur;
        if (sample_valid) begin
            next_cur.prev = sample_data;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end
endmodule // step_check

/* File: tb/actuator_model.sv */
// Behavioural actuator on the driven side: motion sense and brake completion
`timescale 1ns/10ps
module actuator_model #(
    parameter int BRAKE_LEN = 4
) (
    input  wire logic                           sys_clk,
    input  wire logic                           nrst,
    input  wire haptic_loop_pkg::drive_out_type drive,
    input  wire logic                           spinning,
    output logic                                actuator_moving,
    output logic                                brake_done
);
    int cnt;

    // ****************************************
    // Motion sense and brake timing
    // ****************************************
    // A parked actuator never reports motion, whatever the bench asks
    assign actuator_moving = spinning & ~drive.standby;

    // Braking takes a few cycles, so a design that skips the wait is caught
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt        <= 0;
            brake_done <= 1'h0;
        end else begin
            cnt        <= drive.brake ? cnt + 1 : 0;
            brake_done <= drive.brake && (cnt == BRAKE_LEN - 1) && !brake_done;
        end
    end
endmodule // actuator_model

/* File: tb/haptic_drive_loop_config_test.sv */
// Self-checking bench for the drive loop configuration block
`timescale 1ns/10ps
module haptic_drive_loop_config_test;
    logic                           sys_clk, nrst, reg_wr, reg_rd, reg_rvalid;
    logic [7:0]                     reg_addr, reg_wdata, reg_rdata, sample_data;
    logic                           play_start, play_done, idle_timeout, mode_rewrite;
    logic                           trig_level_mode, trigger_irq_pin_in, sample_valid;
    logic                           actuator_moving, brake_done, spinning, actuator_type_sel;
    haptic_loop_pkg::drive_out_type drive;
    int                             n_errors;
    int                             cmp_count;

    haptic_drive_loop_config u_haptic_drive_loop_config (
        .sys_clk(sys_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .play_start(play_start), .play_done(play_done),
        .idle_timeout(idle_timeout), .trig_level_mode(trig_level_mode),
        .trigger_irq_pin_in(trigger_irq_pin_in), .mode_rewrite(mode_rewrite),
        .actuator_moving(actuator_moving), .brake_done(brake_done),
        .sample_valid(sample_valid), .sample_data(sample_data),
        .actuator_type_sel(actuator_type_sel), .drive(drive));

    actuator_model u_actuator_model (
        .sys_clk(sys_clk), .nrst(nrst), .drive(drive), .spinning(spinning),
        .actuator_moving(actuator_moving), .brake_done(brake_done));

    initial begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end

    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        #1;
        check("rvalid", 8'(reg_rvalid), 8'h01);
        check("rdata", reg_rdata, exp);
    endtask

    task automatic sample(input logic [7:0] d, input logic ec, input logic eb);
        @(posedge sys_clk);
        sample_valid <= 1'h1;
        sample_data  <= d;
        @(posedge sys_clk);
        sample_valid <= 1'h0;
        #1;
        check("closed_loop", 8'(drive.closed_loop), 8'(ec));
        check("brake", 8'(drive.brake), 8'(eb));
    endtask

    // 0 start, 1 idle timeout, 2 mode rewrite, 3 pin drop, 4 done
    task automatic pulse(input int k);
        @(posedge sys_clk);
        case (k)
            0: play_start <= 1'h1;
            1: idle_timeout <= 1'h1;
            2: mode_rewrite <= 1'h1;
            3: trigger_irq_pin_in <= 1'h0;
            default: play_done <= 1'h1;
        endcase
        @(posedge sys_clk);
        play_start   <= 1'h0;
        idle_timeout <= 1'h0;
        mode_rewrite <= 1'h0;
        play_done    <= 1'h0;
        #1;
    endtask

    task automatic wait_stby(input logic exp_brk);
        logic seen_brk;
        seen_brk = drive.brake;
        for (int i = 0; i < 20 && drive.standby !== 1'h1; i++) begin
            @(posedge sys_clk);
            #1;
            seen_brk = seen_brk | drive.brake;
        end
        check("standby", 8'(drive.standby), 8'h01);
        check("brake_seen", 8'(seen_brk), 8'(exp_brk));
        check("brake_after", 8'(drive.brake), 8'h00);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        {nrst, reg_wr, reg_rd, play_start, play_done, idle_timeout, mode_rewrite} = '0;
        {trig_level_mode, sample_valid, spinning, reg_addr, reg_wdata, sample_data} = '0;
        trigger_irq_pin_in = 1'h1;
        n_errors = 0;
        cmp_count = 0;
        repeat (3) @(posedge sys_clk);
        nrst <= 1'h1;
        #1;
        check("drive_reset", {4'h0, drive}, 8'h09);
        check("type_reset", 8'(actuator_type_sel), 8'h01);
        rd(haptic_loop_pkg::CFG_OFFSET, haptic_loop_pkg::CFG_RESET);
        wr(haptic_loop_pkg::CFG_OFFSET, 8'h03);
        check("type_sel", 8'(actuator_type_sel), 8'h00);
        rd(haptic_loop_pkg::CFG_OFFSET, 8'h03);
        wr(8'h09, 8'hff);
        rd(8'h09, haptic_loop_pkg::RD_UNMAPPED);
        rd(haptic_loop_pkg::CFG_OFFSET, 8'h03);
        $display("test registers done");
        // Actuator type is settled before any playback
        wr(haptic_loop_pkg::CFG_OFFSET, 8'hc0);
        pulse(0);
        check("standby_play", 8'(drive.standby), 8'h00);
        sample(8'h00, 1'h0, 1'h0);
        // Autobrake only once the closed loop is known to behave
        wr(haptic_loop_pkg::CFG_OFFSET, 8'hd0);
        sample(8'h05, 1'h0, 1'h0);
        sample(8'h00, 1'h1, 1'h1);
        sample(8'h80, 1'h1, 1'h1);
        sample(8'h7f, 1'h0, 1'h0);
        pulse(2);
        check("rewrite_standby", 8'(drive.standby), 8'h01);
        check("rewrite_brake", 8'(drive.brake), 8'h00);
        $display("test open loop done");
        wr(haptic_loop_pkg::CFG_OFFSET, 8'ha4);
        pulse(0);
        sample(8'h00, 1'h1, 1'h0);
        sample(8'h1f, 1'h0, 1'h0);
        sample(8'h3f, 1'h1, 1'h0);
        sample(8'h1f, 1'h1, 1'h0);
        sample(8'h10, 1'h0, 1'h0);
        check("hybrid_on", 8'(drive.hybrid), 8'h01);
        // Hybrid with the step check off stays fully closed, even for a small step
        wr(haptic_loop_pkg::CFG_OFFSET, 8'ha0);
        sample(8'h12, 1'h1, 1'h0);
        wr(haptic_loop_pkg::CFG_OFFSET, 8'h84);
        sample(8'h11, 1'h1, 1'h0);
        check("hybrid_off", 8'(drive.hybrid), 8'h00);
        pulse(4);
        check("done_standby", 8'(drive.standby), 8'h01);
        $display("test hybrid done");
        wr(haptic_loop_pkg::CFG_OFFSET, 8'h88);
        @(posedge sys_clk) spinning <= 1'h1;
        pulse(0);
        pulse(1);
        wait_stby(1'h1);
        @(posedge sys_clk) spinning <= 1'h0;
        pulse(0);
        pulse(1);
        wait_stby(1'h0);
        wr(haptic_loop_pkg::CFG_OFFSET, 8'h80);
        @(posedge sys_clk) spinning <= 1'h1;
        pulse(0);
        pulse(1);
        check("stby_now", 8'({drive.standby, drive.brake}), 8'h02);
        wr(haptic_loop_pkg::CFG_OFFSET, 8'h88);
        @(posedge sys_clk) trig_level_mode <= 1'h1;
        pulse(0);
        pulse(3);
        wait_stby(1'h1);
        // A standby request with nothing playing must not start a brake
        pulse(1);
        check("stby_idle", 8'({drive.standby, drive.brake}), 8'h02);
        @(posedge sys_clk) trigger_irq_pin_in <= 1'h1;
        $display("test standby done");
        wr(haptic_loop_pkg::CFG_OFFSET, 8'h5b);
        pulse(0);
        @(posedge sys_clk) nrst <= 1'h0;
        @(posedge sys_clk) nrst <= 1'h1;
        #1;
        check("drive_rerst", {4'h0, drive}, 8'h09);
        check("rvalid_rerst", 8'(reg_rvalid), 8'h00);
        rd(haptic_loop_pkg::CFG_OFFSET, haptic_loop_pkg::CFG_RESET);
        pulse(0);
        sample(8'h80, 1'h1, 1'h0);
        $display("test second reset done");
        print_verdict();
    end
endmodule // haptic_drive_loop_config_test
